// ---- hw/css_pkg.sv ----
// Purpose: shared constants and carriers for the compacted state save unit
// Assumes: one core clock, wishbone classic register access
// Notes: register offsets are byte addresses of 32-bit words
package css_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK_LO = 8'h08;
	localparam logic [7:0] REG_MASK_HI = 8'h0c;
	localparam logic [7:0] REG_OSMASK_LO = 8'h10;
	localparam logic [7:0] REG_OSMASK_HI = 8'h14;
	localparam logic [7:0] REG_INUSE = 8'h18;
	localparam logic [7:0] REG_SIMD_CS = 8'h1c;
	localparam logic [7:0] REG_ADDR_LO = 8'h20;
	localparam logic [7:0] REG_ADDR_HI = 8'h24;
	localparam logic [7:0] REG_LIMIT = 8'h28;
	localparam logic [7:0] REG_ENV = 8'h2c;
	localparam logic [7:0] REG_HSV_LO = 8'h30;
	localparam logic [7:0] REG_HSV_HI = 8'h34;
	localparam logic [7:0] REG_HCV_LO = 8'h38;
	localparam logic [7:0] REG_HCV_HI = 8'h3c;
	localparam logic [7:0] REG_OPCODE = 8'h40;
	localparam logic [7:0] REG_WRITES = 8'h44;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTRL_GO = 0;
	localparam int CTRL_PAGE_FAULT = 1;
	localparam int ENV_TS = 3;
	localparam int ENV_OSXS = 18;
	localparam int ENV_SAVE_FEAT = 26;
	localparam int ENV_COMPACT_FEAT = 1;
	localparam int ENV_MODE_LSB = 4;
	localparam int ENV_CPL_LSB = 6;
	localparam int ENV_AC_EN = 8;
	localparam int ENV_STACK_SEG = 9;
	localparam int ENV_LOCK = 10;
	localparam int ENV_P66 = 11;
	localparam int ENV_PF3 = 12;
	localparam int ENV_PF2 = 13;
	localparam int ENV_REXW = 14;
	localparam int OP_REG_LSB = 16;
	localparam int OP_MOD_LSB = 19;
	localparam int COMP_X87 = 0;
	localparam int COMP_SSE = 1;
	localparam int COMP_AVX = 2;
	localparam int COMPACT_BIT = 63;
	// ---------------------------------------------------------------
	// constants
	// ---------------------------------------------------------------
	localparam logic [31:0] SIMD_CS_INIT = 32'h0000_1f80;
	localparam logic [5:0] SAVE_ALIGN_MASK = 6'h3f;
	localparam logic [63:0] REAL_TOP = 64'h0000_0000_0000_ffff;
	localparam logic [63:0] AREA_LEN_M1 = 64'h0000_0000_0000_023f;
	localparam logic [7:0] OPC_ESC = 8'h0f;
	localparam logic [7:0] OPC_GRP = 8'hc7;
	localparam logic [2:0] OPC_REG = 3'h4;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [31:0] RESERVED_RD = 32'h0000_0000;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int CPL_USER = 3;
	localparam int CANON_TOP = 47;

	typedef enum logic [1:0] {
		MODE_REAL,
		MODE_PROT,
		MODE_V86_COMPAT,
		MODE_LONG
	} css_mode_t;

	typedef enum logic [3:0] {
		FLT_NONE = 4'h0,
		FLT_UD = 4'h1,
		FLT_NM = 4'h2,
		FLT_GP = 4'h3,
		FLT_SS = 4'h4,
		FLT_AC = 4'h5,
		FLT_PF = 4'h6
	} css_fault_t;

	// one store request to the memory path
	typedef struct packed {
		logic x87;
		logic sse;
		logic avx;
		logic hdr;
	} css_store_t;
endpackage : css_pkg

// ---- hw/css_unit.sv ----
// What this block does
// (R1) requested bitmap is mask pair AND os mask
// (R2) x87 saved when requested and in use
// (R3) sse saved if requested and used or control nondefault
// (R4) avx saved when requested and in use
// (R5) legacy bytes 511..464 never written
// (R6) header state vector is requested AND in use
// (R7) nondefault simd control forces state bit one
// (R8) compaction vector bit 63 set, low bits requested
// (R9) only the two header vectors are written
// (R10) extended region always uses compacted layout
// (R11) unaligned 64-byte destination raises protection fault
// (R12) upper halves of mask pair ignored
// (R13) segment limit overruns raise protection or stack fault
// (R14) task switched flag raises device unavailable
// (R15) missing feature or os enable is invalid opcode
// (R16) lock or 66 f3 f2 prefix is invalid opcode
// (R17) real mode operand beyond ffff faults
// (R18) noncanonical address faults, stack gives stack fault
// (R19) alignment check may replace protection fault at level 3
// (R20) v86 and compat use protected rules
// (R21) decode 0f c7 /4 memory, wide only long mode
// (R22) paging fault on store reports paging fault
// (R23) os mask lists only managed components
// (R24) all checks complete before any write
// (R25) arithmetic flags untouched
//
// Purpose: compacted state save execution unit behind wishbone registers
// Assumes: core environment bits are written by software before go
// Notes: store requests are one-cycle pulses on the store struct
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module css_unit (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output css_pkg::css_store_t store_o,
	output logic store_valid_o,
	output logic busy_o,
	output logic [3:0] fault_o
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_s1_r;
	logic rst_s2_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] din, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[8*i +: 8] = din[8*i +: 8];
		end
		return r;
	endfunction : wmerge

	function automatic logic canonical(input logic [63:0] a);
		return (a[63:css_pkg::CANON_TOP] == '0) ||
			(a[63:css_pkg::CANON_TOP] == '1);
	endfunction : canonical

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [31:0] mask_lo_r;
	logic [31:0] mask_hi_r;
	logic [31:0] os_lo_r;
	logic [31:0] os_hi_r;
	logic [31:0] inuse_r;
	logic [31:0] simd_cs_r;
	logic [31:0] addr_lo_r;
	logic [31:0] addr_hi_r;
	logic [31:0] limit_r;
	logic [31:0] env_r;
	logic [31:0] opcode_r;
	logic [63:0] hsv_r;
	logic [63:0] hcv_r;
	logic [31:0] writes_r;
	logic wb_req;
	logic wr_go;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_go = wb_req && wb_we_i && wb_adr_i == css_pkg::REG_CTRL &&
		wb_sel_i[0] && wb_dat_i[css_pkg::CTRL_GO];

	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			ctrl_r <= css_pkg::CTRL_RST;
			mask_lo_r <= '0;
			mask_hi_r <= '0;
			os_lo_r <= '0;
			os_hi_r <= '0;
			inuse_r <= '0;
			simd_cs_r <= css_pkg::SIMD_CS_INIT;
			addr_lo_r <= '0;
			addr_hi_r <= '0;
			limit_r <= '0;
			env_r <= '0;
			opcode_r <= '0;
		end else if (wb_req && wb_we_i) begin
			case (wb_adr_i)
			css_pkg::REG_CTRL: ctrl_r <= wmerge(ctrl_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_MASK_LO:
				mask_lo_r <= wmerge(mask_lo_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_MASK_HI:
				mask_hi_r <= wmerge(mask_hi_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_OSMASK_LO:
				os_lo_r <= wmerge(os_lo_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_OSMASK_HI:
				os_hi_r <= wmerge(os_hi_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_INUSE:
				inuse_r <= wmerge(inuse_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_SIMD_CS:
				simd_cs_r <= wmerge(simd_cs_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_ADDR_LO:
				addr_lo_r <= wmerge(addr_lo_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_ADDR_HI:
				addr_hi_r <= wmerge(addr_hi_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_LIMIT:
				limit_r <= wmerge(limit_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_ENV: env_r <= wmerge(env_r, wb_dat_i, wb_sel_i);
			css_pkg::REG_OPCODE:
				opcode_r <= wmerge(opcode_r, wb_dat_i, wb_sel_i);
			default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// bitmaps and header vectors
	// ---------------------------------------------------------------
	css_pkg::css_mode_t mode;
	logic [63:0] mask_pair;
	logic [63:0] os_mask;
	logic [63:0] req_bm;
	logic [63:0] inuse64;
	logic simd_nondef;
	logic [63:0] addr;
	assign mode = css_pkg::css_mode_t'(env_r[css_pkg::ENV_MODE_LSB +: 2]);
	// 32-bit halves already; upper register bits never exist here
	assign mask_pair = {mask_hi_r, mask_lo_r}; // R12
	assign os_mask = {os_hi_r, os_lo_r}; // R23
	assign req_bm = mask_pair & os_mask; // R1
	assign inuse64 = {32'h0000_0000, inuse_r};
	assign simd_nondef = simd_cs_r != css_pkg::SIMD_CS_INIT;
	assign addr = {addr_hi_r, addr_lo_r};

	logic [63:0] hsv_nxt;
	logic [63:0] hcv_nxt;
	always_comb begin
		hsv_nxt = req_bm & inuse64; // R6
		if (req_bm[css_pkg::COMP_SSE] && simd_nondef)
			hsv_nxt[css_pkg::COMP_SSE] = 1'b1; // R7
		hcv_nxt = req_bm; // R8
		hcv_nxt[css_pkg::COMPACT_BIT] = 1'b1; // R8 R10
	end

	// ---------------------------------------------------------------
	// fault checks, in priority order
	// ---------------------------------------------------------------
	logic [7:0] opc_esc;
	logic [7:0] opc_grp;
	logic [2:0] opc_reg;
	logic [1:0] opc_mod;
	logic misaligned;
	logic [63:0] last_byte;
	logic user_ac;
	css_pkg::css_fault_t chk_fault;
	assign opc_esc = opcode_r[7:0];
	assign opc_grp = opcode_r[15:8];
	assign opc_reg = opcode_r[css_pkg::OP_REG_LSB +: 3];
	assign opc_mod = opcode_r[css_pkg::OP_MOD_LSB +: 2];
	assign misaligned = (addr[5:0] & css_pkg::SAVE_ALIGN_MASK) != 6'h00;
	assign last_byte = addr + css_pkg::AREA_LEN_M1;
	assign user_ac = env_r[css_pkg::ENV_AC_EN] &&
		env_r[css_pkg::ENV_CPL_LSB +: 2] == 2'(css_pkg::CPL_USER);

	always_comb begin
		chk_fault = css_pkg::FLT_NONE;
		if (opc_esc != css_pkg::OPC_ESC || opc_grp != css_pkg::OPC_GRP ||
			opc_reg != css_pkg::OPC_REG || opc_mod == css_pkg::MOD_REG ||
			(env_r[css_pkg::ENV_REXW] && mode != css_pkg::MODE_LONG))
			chk_fault = css_pkg::FLT_UD; // R21
		else if (env_r[css_pkg::ENV_LOCK] || env_r[css_pkg::ENV_P66] ||
			env_r[css_pkg::ENV_PF3] || env_r[css_pkg::ENV_PF2])
			chk_fault = css_pkg::FLT_UD; // R16
		else if (!env_r[css_pkg::ENV_SAVE_FEAT] ||
			!env_r[css_pkg::ENV_COMPACT_FEAT] ||
			!env_r[css_pkg::ENV_OSXS])
			chk_fault = css_pkg::FLT_UD; // R15
		else if (env_r[css_pkg::ENV_TS])
			chk_fault = css_pkg::FLT_NM; // R14
		else if (misaligned)
			// alignment check offered only in user mode with checking on
			chk_fault = user_ac ? css_pkg::FLT_AC : css_pkg::FLT_GP; // R11 R19
		else begin
			case (mode)
			css_pkg::MODE_REAL:
				if (last_byte > css_pkg::REAL_TOP || last_byte < addr)
					chk_fault = css_pkg::FLT_GP; // R17
			css_pkg::MODE_PROT, css_pkg::MODE_V86_COMPAT: // R20
				if (last_byte > {32'h0000_0000, limit_r} ||
					last_byte < addr)
					chk_fault = env_r[css_pkg::ENV_STACK_SEG] ?
						css_pkg::FLT_SS : css_pkg::FLT_GP; // R13
			css_pkg::MODE_LONG:
				if (!canonical(addr) || !canonical(last_byte))
					chk_fault = env_r[css_pkg::ENV_STACK_SEG] ?
						css_pkg::FLT_SS : css_pkg::FLT_GP; // R18
			default: chk_fault = css_pkg::FLT_GP;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// sequencer: check, then x87, sse, avx, header
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_X87,
		ST_SSE,
		ST_AVX,
		ST_HDR
	} css_state_t;
	css_state_t state_r;
	css_state_t state_nxt;
	logic fault_hit;
	logic pf_now;
	assign fault_hit = chk_fault != css_pkg::FLT_NONE;
	// paging fault injected by software through control bit CTRL_PAGE_FAULT
	assign pf_now = ctrl_r[css_pkg::CTRL_PAGE_FAULT];

	always_comb begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: if (wr_go) state_nxt = ST_CHECK;
		ST_CHECK: state_nxt = fault_hit ? ST_IDLE : ST_X87; // R24
		ST_X87: state_nxt = pf_now ? ST_IDLE : ST_SSE;
		ST_SSE: state_nxt = pf_now ? ST_IDLE : ST_AVX;
		ST_AVX: state_nxt = pf_now ? ST_IDLE : ST_HDR;
		ST_HDR: state_nxt = ST_IDLE;
		default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// store pulses; legacy tail bytes have no request kind at all
	css_pkg::css_store_t store_nxt;
	always_comb begin
		store_nxt = '0;
		case (state_r)
		ST_X87: store_nxt.x87 = !pf_now && req_bm[css_pkg::COMP_X87] &&
			inuse_r[css_pkg::COMP_X87]; // R2 R5
		ST_SSE: store_nxt.sse = !pf_now && req_bm[css_pkg::COMP_SSE] &&
			(inuse_r[css_pkg::COMP_SSE] || simd_nondef); // R3
		ST_AVX: store_nxt.avx = !pf_now && req_bm[css_pkg::COMP_AVX] &&
			inuse_r[css_pkg::COMP_AVX]; // R4 R10
		ST_HDR: store_nxt.hdr = 1'b1; // R9
		default: store_nxt = '0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			store_o <= '0;
			store_valid_o <= 1'b0;
		end else begin
			store_o <= store_nxt;
			store_valid_o <= |store_nxt;
		end
	end

	// header vectors latched once checks pass
	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			hsv_r <= '0;
			hcv_r <= '0;
		end else if (state_r == ST_CHECK && !fault_hit) begin
			hsv_r <= hsv_nxt;
			hcv_r <= hcv_nxt;
		end
	end

	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r)
			writes_r <= '0;
		else if (wr_go && state_r == ST_IDLE)
			writes_r <= '0;
		else if (|store_nxt)
			writes_r <= writes_r + 32'h0000_0001;
	end

	// fault code; flags are never touched by this unit
	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r)
			fault_o <= css_pkg::FLT_NONE;
		else if (wr_go && state_r == ST_IDLE)
			fault_o <= css_pkg::FLT_NONE;
		else if (state_r == ST_CHECK)
			fault_o <= chk_fault; // R24 R25
		else if (pf_now && (state_r == ST_X87 || state_r == ST_SSE ||
			state_r == ST_AVX))
			fault_o <= css_pkg::FLT_PF; // R22
	end

	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r)
			busy_o <= 1'b0;
		else
			busy_o <= state_nxt != ST_IDLE;
	end

	// ---------------------------------------------------------------
	// wishbone answer, one cycle after the request
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			case (wb_adr_i)
			css_pkg::REG_CTRL: wb_dat_o <= ctrl_r;
			css_pkg::REG_STATUS:
				wb_dat_o <= {27'h0000000, fault_o, busy_o};
			css_pkg::REG_MASK_LO: wb_dat_o <= mask_lo_r;
			css_pkg::REG_MASK_HI: wb_dat_o <= mask_hi_r;
			css_pkg::REG_OSMASK_LO: wb_dat_o <= os_lo_r;
			css_pkg::REG_OSMASK_HI: wb_dat_o <= os_hi_r;
			css_pkg::REG_INUSE: wb_dat_o <= inuse_r;
			css_pkg::REG_SIMD_CS: wb_dat_o <= simd_cs_r;
			css_pkg::REG_ADDR_LO: wb_dat_o <= addr_lo_r;
			css_pkg::REG_ADDR_HI: wb_dat_o <= addr_hi_r;
			css_pkg::REG_LIMIT: wb_dat_o <= limit_r;
			css_pkg::REG_ENV: wb_dat_o <= env_r;
			css_pkg::REG_HSV_LO: wb_dat_o <= hsv_r[31:0];
			css_pkg::REG_HSV_HI: wb_dat_o <= hsv_r[63:32];
			css_pkg::REG_HCV_LO: wb_dat_o <= hcv_r[31:0];
			css_pkg::REG_HCV_HI: wb_dat_o <= hcv_r[63:32];
			css_pkg::REG_OPCODE: wb_dat_o <= opcode_r;
			css_pkg::REG_WRITES: wb_dat_o <= writes_r;
			default: wb_dat_o <= css_pkg::RESERVED_RD;
			endcase
		end
	end
endmodule : css_unit

// ---- verif/css_store_model.sv ----
// Purpose: memory store path model beside the save unit
// Assumes: store pulses last one cycle each
// Notes: counts each kind of store in one byte, hdr in the low byte
`timescale 1ns/1ps
module css_store_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire css_pkg::css_store_t store,
	input wire logic store_valid,
	output logic [31:0] seen
);
	logic [3:0] bits;
	assign bits = store;
	// counters wrap at 256, far more than one run issues
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seen <= 32'h0;
		end else if (store_valid) begin
			for (int k = 0; k < 4; k++) begin
				seen[8*k +: 8] <= seen[8*k +: 8] + {7'h0, bits[k]};
			end
		end
	end
endmodule : css_store_model

// ---- verif/css_unit_bench.sv ----
// Purpose: register-level tests of the save unit
// Assumes: wishbone classic, one idle cycle between requests
// Notes: env words hold mode, prefixes and feature bits
`timescale 1ns/1ps
module css_unit_bench;
	logic clock, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic store_valid_o, busy_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, cnt, rd, simd, inuse, base;
	logic [3:0] wb_sel_i, fault_o;
	logic [63:0] mask, osm, requested_feature_bitmap, hsv;
	css_pkg::css_store_t store_o;
	int miscompares, checks_done;
	string nm[4] = '{"hdr", "avx", "sse", "x87"};
	localparam logic [31:0] LNG = 32'h0404_0032;
	localparam logic [31:0] PRT = 32'h0404_0012;
	localparam logic [31:0] RL = 32'h0404_0002;
	localparam logic [31:0] V86 = 32'h0404_0022;
	localparam logic [31:0] OPC = 32'h0004_c70f;

	css_unit uut (.clock(clock), .rst_n(rst_n), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .store_o(store_o),
		.store_valid_o(store_valid_o), .busy_o(busy_o), .fault_o(fault_o));
	css_store_model model (.clock(clock), .rst_n(rst_n), .store(store_o),
		.store_valid(store_valid_o), .seen(cnt));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic wb(input logic [7:0] a, input logic we,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	task automatic setup(input logic [63:0] m, input logic [63:0] o,
		input logic [31:0] iu, input logic [31:0] sc);
		mask = m;
		osm = o;
		inuse = iu;
		simd = sc;
		wb(css_pkg::REG_MASK_LO, 1'b1, m[31:0]);
		wb(css_pkg::REG_MASK_HI, 1'b1, m[63:32]);
		wb(css_pkg::REG_OSMASK_LO, 1'b1, o[31:0]);
		wb(css_pkg::REG_OSMASK_HI, 1'b1, o[63:32]);
		wb(css_pkg::REG_INUSE, 1'b1, iu);
		wb(css_pkg::REG_SIMD_CS, 1'b1, sc);
	endtask : setup

	task automatic run(input logic [31:0] env, input logic [63:0] ad,
		input logic [31:0] ctl, input logic [3:0] ef, input logic [3:0] cm);
		logic [31:0] c0;
		logic [3:0] es;
		int n;
		requested_feature_bitmap = mask & osm;
		hsv = requested_feature_bitmap & {32'h0, inuse};
		if (requested_feature_bitmap[1] && simd !== css_pkg::SIMD_CS_INIT) hsv[1] = 1'b1;
		es = (ef != 4'h0) ? 4'h0 : {hsv[0], hsv[1], hsv[2], 1'b1};
		wb(css_pkg::REG_ENV, 1'b1, env);
		wb(css_pkg::REG_ADDR_LO, 1'b1, ad[31:0]);
		wb(css_pkg::REG_ADDR_HI, 1'b1, ad[63:32]);
		c0 = cnt;
		wb(css_pkg::REG_CTRL, 1'b1, ctl);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (busy_o !== 1'b0 && n < 50);
		repeat (3) @(posedge clock);
		chk("fault_o", {28'h0, ef}, {28'h0, fault_o});
		for (int k = 0; k < 4; k++) begin
			if (cm[k]) chk(nm[k], {31'h0, es[k]},
				{24'h0, cnt[8*k +: 8] - c0[8*k +: 8]});
		end
		if (ef == 4'h0) begin
			wb(css_pkg::REG_HSV_LO, 1'b0, 32'h0);
			chk("hsv lo", hsv[31:0], rd);
			wb(css_pkg::REG_HSV_HI, 1'b0, 32'h0);
			chk("hsv hi", hsv[63:32], rd);
			wb(css_pkg::REG_HCV_LO, 1'b0, 32'h0);
			chk("hcv lo", requested_feature_bitmap[31:0], rd);
			wb(css_pkg::REG_HCV_HI, 1'b0, 32'h0);
			chk("hcv hi", {1'b1, requested_feature_bitmap[62:32]}, rd);
		end
		$display("Test env %h addr %h done", env, ad);
	endtask : run

	task automatic complete_run;
		$display("Checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		complete_run();
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		wb_we_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		miscompares = 0;
		checks_done = 0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		wb(css_pkg::REG_CTRL, 1'b0, 32'h0);
		chk("ctrl reset", css_pkg::CTRL_RST, rd);
		chk("status reset", 32'h0, {27'h0, fault_o, busy_o});
		wb(css_pkg::REG_SIMD_CS, 1'b0, 32'h0);
		chk("simd reset", css_pkg::SIMD_CS_INIT, rd);
		wb(8'h80, 1'b1, 32'hdead_beef);
		wb(8'h80, 1'b0, 32'h0);
		chk("unmapped", css_pkg::RESERVED_RD, rd);
		wb(css_pkg::REG_OPCODE, 1'b1, OPC);
		wb(css_pkg::REG_LIMIT, 1'b1, 32'hffff_ffff);
		$display("Test registers done");
		setup(64'hffff_ffff_ffff_ffff, 64'h8000_0000_0000_0007, 32'h5,
			32'h1f80);
		run(LNG, 64'h1000, 32'h1, 4'h0, 4'hf);
		setup(64'h2, 64'h7, 32'h0, 32'h0);
		run(LNG, 64'h1040, 32'h1, 4'h0, 4'hf);
		setup(64'h7, 64'h7, 32'h2, 32'h1f80);
		run(PRT, 64'h2000, 32'h1, 4'h0, 4'hf);
		run(V86, 64'h2000, 32'h1, 4'h0, 4'hf);
		run(RL, 64'hfdc0, 32'h1, 4'h0, 4'hf);
		setup(64'h7, 64'h7, 32'h7, 32'h1f80);
		run(LNG | 32'h8, 64'h1000, 32'h1, 4'h2, 4'hf);
		run(LNG & ~32'h0004_0000, 64'h1000, 32'h1, 4'h1, 4'hf);
		run(LNG & ~32'h0400_0000, 64'h1000, 32'h1, 4'h1, 4'hf);
		run(LNG & ~32'h2, 64'h1000, 32'h1, 4'h1, 4'hf);
		for (int p = 10; p < 14; p++) begin
			run(LNG | (32'h1 << p), 64'h1000, 32'h1, 4'h1, 4'hf);
		end
		run(PRT | 32'h4000, 64'h1000, 32'h1, 4'h1, 4'hf);
		run(LNG | 32'h4000, 64'h1000, 32'h1, 4'h0, 4'hf);
		run(LNG, 64'h1008, 32'h1, 4'h3, 4'hf);
		run(RL, 64'h1020, 32'h1, 4'h3, 4'hf);
		run(LNG | 32'h1c0, 64'h1008, 32'h1, 4'h5, 4'hf);
		run(LNG | 32'h100, 64'h1008, 32'h1, 4'h3, 4'hf);
		run(LNG, 64'h0001_0000_0000_1000, 32'h1, 4'h3, 4'hf);
		run(LNG | 32'h200, 64'h0001_0000_0000_1000, 32'h1, 4'h4,
			4'hf);
		run(RL, 64'hffc0, 32'h1, 4'h3, 4'hf);
		wb(css_pkg::REG_LIMIT, 1'b1, 32'h0000_1100);
		run(PRT, 64'h1000, 32'h1, 4'h3, 4'hf);
		run(PRT | 32'h200, 64'h1000, 32'h1, 4'h4, 4'hf);
		run(V86 | 32'h200, 64'h1000, 32'h1, 4'h4, 4'hf);
		wb(css_pkg::REG_LIMIT, 1'b1, 32'hffff_ffff);
		wb(css_pkg::REG_OPCODE, 1'b1, 32'h0003_c70f);
		run(LNG, 64'h1000, 32'h1, 4'h1, 4'hf);
		wb(css_pkg::REG_OPCODE, 1'b1, 32'h001c_c70f);
		run(LNG, 64'h1000, 32'h1, 4'h1, 4'hf);
		wb(css_pkg::REG_OPCODE, 1'b1, OPC);
		run(LNG, 64'h1000, 32'h3, 4'h6, 4'hf);
		wb(css_pkg::REG_STATUS, 1'b0, 32'h0);
		chk("status", {27'h0, css_pkg::FLT_PF, 1'b0}, rd);
		wb(css_pkg::REG_CTRL, 1'b1, 32'h0);
		run(LNG, 64'h1000, 32'h1, 4'h0, 4'hf);
		wb(css_pkg::REG_WRITES, 1'b0, 32'h0);
		chk("writes", 32'h4, rd);
		// a second go while the run is still busy must be refused
		base = cnt;
		wb(css_pkg::REG_CTRL, 1'b1, 32'h1);
		wb(css_pkg::REG_CTRL, 1'b1, 32'h1);
		repeat (10) @(posedge clock);
		chk("hdr once", 32'h1, {24'h0, cnt[7:0] - base[7:0]});
		wb(css_pkg::REG_WRITES, 1'b0, 32'h0);
		chk("writes busy go", 32'h4, rd);
		$display("Test busy go done");
		complete_run();
	end
endmodule : css_unit_bench

// ---- verif/css_unit_chk.sv ----
// Purpose: port-level checker for the save unit
// Assumes: timing of the hand-over walk
// Notes: attached by bind below
`timescale 1ns/1ps
module css_unit_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire css_pkg::css_store_t store_o,
	input wire logic store_valid_o,
	input wire logic busy_o,
	input wire logic [3:0] fault_o
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_ACK_NEXT:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE:
		assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_VALID_OR:
		assert property (store_valid_o == (|store_o))
		else $error("store valid differs from store bits");
	AST_ONE_STORE:
		assert property ($onehot0(store_o))
		else $error("two stores at once");
	AST_NO_STORE_ON_FAULT:
		assert property (fault_o != 4'h0 && fault_o != css_pkg::FLT_PF
			|-> !store_valid_o)
		else $error("store issued with fault");
	AST_HDR_AT_END:
		assert property (store_o.hdr |-> $past(busy_o) && !busy_o)
		else $error("header store out of place");
	AST_PF_NO_HDR:
		assert property (fault_o == css_pkg::FLT_PF |-> !store_o.hdr)
		else $error("header written after paging fault");
	AST_STATE_IN_RUN:
		assert property (store_o.x87 || store_o.sse || store_o.avx
			|-> $past(busy_o) && busy_o)
		else $error("state store outside run");
	AST_BUSY_BOUND:
		assert property ($rose(busy_o) |-> ##[1:8] !busy_o)
		else $error("run too long");
	COV_HDR: cover property (store_o.hdr);
	COV_AC: cover property (fault_o == css_pkg::FLT_AC);
	COV_PF: cover property (fault_o == css_pkg::FLT_PF);
endmodule : css_unit_chk

bind css_unit css_unit_chk chk (.clock(clock), .rst_n(rst_n),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .store_o(store_o),
	.store_valid_o(store_valid_o), .busy_o(busy_o), .fault_o(fault_o));
